/* File: daisy_chain_serial_control_port.sv */
// serial control port with daisy-chain through output and register store
`timescale 1ns/1ps
module daisy_chain_serial_control_port (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic serial_clk_i,
  input wire logic chip_sel_n_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  output logic daisy_through_out_o,
  output logic wr_valid_o,
  output spi_chain_pkg::reg_write_t wr_o,
  output logic resync_o
);

  // ----------------------------------------------------------------------
  // link-domain reset
  // ----------------------------------------------------------------------
  logic rst_meta;
  logic link_rst_n;

  // the link clock may stop, so reset only takes hold once it toggles
  always_ff @(posedge serial_clk_i)
  begin
    rst_meta <= reset_n_i;
    link_rst_n <= rst_meta;
  end

  // ----------------------------------------------------------------------
  // receive side, rising edge
  // ----------------------------------------------------------------------
  spi_chain_pkg::xfer_state_t state;
  logic [2:0] cnt;
  logic [7:0] sr;
  logic broadcast_flag;
  logic rw;
  logic hit;
  logic [spi_chain_pkg::ADDR_W-1:0] addr;
  logic borrow;
  logic wr_tog;
  logic resync_tog;
  spi_chain_pkg::reg_write_t wr_hold;
  logic commit;
  logic [7:0] regs [spi_chain_pkg::REG_DEPTH];

  assign commit = !chip_sel_n_i && cnt == spi_chain_pkg::BIT_LAST
                  && state == spi_chain_pkg::ST_DATA && !rw && hit;

  always_ff @(posedge serial_clk_i)
  begin
    if (!link_rst_n)
    begin
      state <= spi_chain_pkg::ST_CTRL;
      cnt <= spi_chain_pkg::BIT_FIRST;
      sr <= 8'h00;
      broadcast_flag <= 1'b0;
      rw <= 1'b0;
      hit <= 1'b0;
      addr <= '0;
      resync_tog <= 1'b0;
    end
    else if (chip_sel_n_i)
    begin
      if (cnt != spi_chain_pkg::BIT_FIRST)
      begin
        state <= spi_chain_pkg::ST_CTRL;
        cnt <= spi_chain_pkg::BIT_FIRST;
        resync_tog <= ~resync_tog;
      end
      else if (state == spi_chain_pkg::ST_EXTRA)
        state <= spi_chain_pkg::ST_CTRL;
    end
    else
    begin
      sr <= {sr[6:0], serial_in_i};
      cnt <= cnt + 3'h1;
      if (state == spi_chain_pkg::ST_CTRL && cnt == spi_chain_pkg::BIT_FIRST)
        broadcast_flag <= serial_in_i;
      if (cnt == spi_chain_pkg::BIT_LAST)
      begin
        unique case (state)
          spi_chain_pkg::ST_CTRL:
          begin
            rw <= sr[spi_chain_pkg::CTRL_RW_POS - 1];
            // fixed bits must match, else the whole operation is ignored
            hit <= (sr[spi_chain_pkg::CTRL_ONE_POS-1:spi_chain_pkg::CTRL_ZERO_POS-1]
                    == spi_chain_pkg::CTRL_FIXED)
                   && (sr[spi_chain_pkg::CTRL_BROADCAST_FLAG_POS - 1]
                       || {serial_in_i, sr[0], sr[1], sr[2]} == spi_chain_pkg::CID_SELF);
            state <= spi_chain_pkg::ST_ADDR;
          end
          spi_chain_pkg::ST_ADDR:
          begin
            addr <= {sr[4:0], serial_in_i};
            state <= spi_chain_pkg::ST_DATA;
          end
          spi_chain_pkg::ST_DATA:
            state <= spi_chain_pkg::ST_EXTRA;
          spi_chain_pkg::ST_EXTRA:
            state <= spi_chain_pkg::ST_CTRL;
        endcase
      end
    end
  end

  // serial decrement of the channel field, least significant bit first
  always_ff @(posedge serial_clk_i)
  begin
    if (!link_rst_n)
      borrow <= 1'b1;
    else if (!chip_sel_n_i && state == spi_chain_pkg::ST_CTRL)
    begin
      if (cnt == spi_chain_pkg::CID_FIRST)
        borrow <= ~serial_in_i;
      else if (cnt > spi_chain_pkg::CID_FIRST)
        borrow <= borrow & ~serial_in_i;
    end
  end

  // register store and write hand-off
  always_ff @(posedge serial_clk_i)
  begin
    if (!link_rst_n)
    begin
      for (int i = 0; i < spi_chain_pkg::REG_DEPTH; i++)
      begin
        regs[i] <= spi_chain_pkg::REG_RESET;
      end
      wr_tog <= 1'b0;
      wr_hold <= '0;
    end
    else if (commit)
    begin
      regs[addr] <= {sr[6:0], serial_in_i};
      wr_hold <= {addr, sr[6:0], serial_in_i};
      wr_tog <= ~wr_tog;
    end
  end

  // ----------------------------------------------------------------------
  // transmit side, falling edge
  // ----------------------------------------------------------------------
  logic inv;
  logic [6:0] rd_bits;
  logic rd_active;

  // broadcast reads are not driven, which avoids contention on a shared line
  assign rd_active = (state == spi_chain_pkg::ST_DATA || state == spi_chain_pkg::ST_EXTRA)
                     && rw && hit && !broadcast_flag;

  always_ff @(negedge serial_clk_i)
  begin
    if (!link_rst_n)
      inv <= 1'b0;
    else
    begin
      inv <= !chip_sel_n_i && state == spi_chain_pkg::ST_CTRL && !broadcast_flag
             && cnt >= spi_chain_pkg::CID_FIRST
             && (cnt == spi_chain_pkg::CID_FIRST || borrow);
    end
  end

  always_ff @(negedge serial_clk_i)
  begin
    if (!link_rst_n)
    begin
      serial_out_o <= 1'b0;
      serial_out_oe_o <= 1'b0;
      rd_bits <= 7'h00;
    end
    else if (!chip_sel_n_i && rd_active)
    begin
      serial_out_oe_o <= 1'b1;
      if (cnt == spi_chain_pkg::BIT_FIRST)
      begin
        {serial_out_o, rd_bits} <= regs[addr];
      end
      else
      begin
        serial_out_o <= rd_bits[6];
        rd_bits <= {rd_bits[5:0], 1'b0};
      end
    end
    else
      serial_out_oe_o <= 1'b0;
  end

  // through path stays combinational so the chain adds no bit delay
  assign daisy_through_out_o = serial_in_i ^ inv;

  // ----------------------------------------------------------------------
  // system-clock side
  // ----------------------------------------------------------------------
  logic wr_pulse;
  logic resync_pulse;

  toggle_sync u_wr_sync (
    .clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .toggle_i(wr_tog),
    .pulse_o(wr_pulse)
  );

  toggle_sync u_resync_sync (
    .clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .toggle_i(resync_tog),
    .pulse_o(resync_pulse)
  );

  // wr_hold is stable for a whole byte time after its toggle, so it is safe
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      wr_valid_o <= 1'b0;
      wr_o <= '0;
      resync_o <= 1'b0;
    end
    else if (ce_i)
    begin
      wr_valid_o <= wr_pulse;
      resync_o <= resync_pulse;
      if (wr_pulse)
        wr_o <= wr_hold;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  AST_BYTE_WRAP: assert property (@(posedge serial_clk_i) disable iff (!link_rst_n)
    !chip_sel_n_i && cnt == spi_chain_pkg::BIT_LAST |=> cnt == spi_chain_pkg::BIT_FIRST)
    else $error("bit count did not wrap after eight bits");

  AST_RESYNC: assert property (@(posedge serial_clk_i) disable iff (!link_rst_n)
    chip_sel_n_i && cnt != spi_chain_pkg::BIT_FIRST
    |=> cnt == spi_chain_pkg::BIT_FIRST && state == spi_chain_pkg::ST_CTRL)
    else $error("mid-byte release did not reset the machine");

  AST_ADDR_SIX: assert property (@(posedge serial_clk_i) disable iff (!link_rst_n)
    !chip_sel_n_i && cnt == spi_chain_pkg::BIT_LAST && state == spi_chain_pkg::ST_ADDR
    |=> addr == {$past(sr[4:0]), $past(serial_in_i)} && state == spi_chain_pkg::ST_DATA)
    else $error("address not taken from six low bits");

  AST_MSB_FIRST: assert property (@(posedge serial_clk_i) disable iff (!link_rst_n)
    !chip_sel_n_i ##1 !chip_sel_n_i |=> sr[1:0] == {$past(serial_in_i, 2), $past(serial_in_i)})
    else $error("shift order is not msb first");

  AST_COMMIT: assert property (@(posedge serial_clk_i) disable iff (!link_rst_n)
    $changed(wr_tog) |-> $past(state) == spi_chain_pkg::ST_DATA
    && $past(cnt) == spi_chain_pkg::BIT_LAST && !$past(rw))
    else $error("write committed before the data byte ended");

  AST_THRU_WIN: assert property (@(negedge serial_clk_i) disable iff (!link_rst_n)
    inv |-> $past(state) == spi_chain_pkg::ST_CTRL
    && $past(cnt) >= spi_chain_pkg::CID_FIRST && !$past(chip_sel_n_i))
    else $error("through data altered outside the channel field");

  AST_BROADCAST_FLAG_PASS: assert property (@(posedge serial_clk_i) disable iff (!link_rst_n)
    broadcast_flag && state == spi_chain_pkg::ST_CTRL && cnt > spi_chain_pkg::CID_FIRST |-> !inv)
    else $error("broadcast channel field was changed");

  AST_SDO_OE: assert property (@(posedge serial_clk_i) disable iff (!link_rst_n)
    serial_out_oe_o |-> rw && hit && !broadcast_flag
    && (state == spi_chain_pkg::ST_DATA || state == spi_chain_pkg::ST_EXTRA))
    else $error("output driven outside a selected read");

  AST_WR_PULSE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    wr_valid_o && ce_i |=> !wr_valid_o)
    else $error("write strobe longer than one cycle");

endmodule : daisy_chain_serial_control_port

/* File: spi_chain_pkg.sv */
// shared constants, states and carriers of the daisy-chained serial control port
package spi_chain_pkg;

  // ----------------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int REG_DEPTH = 64;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] CID_FIRST = 3'h4;

  // ----------------------------------------------------------------------
  // control byte fields
  // ----------------------------------------------------------------------
  localparam int CTRL_BROADCAST_FLAG_POS = 7;
  localparam int CTRL_RW_POS = 6;
  localparam int CTRL_ONE_POS = 5;
  localparam int CTRL_ZERO_POS = 4;
  localparam logic [1:0] CTRL_FIXED = 2'h2;
  localparam logic [3:0] CID_SELF = 4'h0;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;

  typedef enum logic [1:0] {
    ST_CTRL = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10,
    ST_EXTRA = 2'b11
  } xfer_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } reg_write_t;

endpackage : spi_chain_pkg

/* File: toggle_sync.sv */
// toggle-to-pulse event synchroniser
`timescale 1ns/1ps
module toggle_sync (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic toggle_i,
  output logic pulse_o
);

  logic meta;
  logic sync;
  logic last;

  // meta feeds only sync
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
      pulse_o <= 1'b0;
    end
    else if (ce_i)
    begin
      meta <= toggle_i;
      sync <= meta;
      last <= sync;
      pulse_o <= sync ^ last;
    end
  end

endmodule : toggle_sync

/* File: spi_host_model.sv */
// serial host controller model for the daisy-chained control port
`timescale 1ns/1ps
module spi_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  input wire logic thru_i
);
  initial
  begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end

  // clock idles high and runs inside transfers and in stop with select high, 12 ns period
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx,
                      output logic [7:0] th);
    rx = 8'hzz;
    th = 8'hzz;
    // select moves off the rising edge, so the device never sees it change there
    #3 cs_n_o = 1'b0;
    for (int i = 7; i > 7 - n; i--)
    begin
      #6 sclk_o = 1'b0;
      sdi_o = tx[i];
      #6 sclk_o = 1'b1;
      rx[i] = sdo_oe_i ? sdo_i : 1'bz;
      th[i] = thru_i;
    end
  endtask : xfer

  // select rises only after the last rising edge; data line shows a stale inverse
  task automatic stop(input int n);
    #3 cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    repeat (n)
    begin
      #6 sclk_o = 1'b0;
      #6 sclk_o = 1'b1;
    end
  endtask : stop
endmodule : spi_host_model

/* File: daisy_chain_serial_control_port_tb.sv */
// self-checking bench of the daisy-chained serial control port
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module daisy_chain_serial_control_port_tb;
  logic sys_clk_i, reset_n_i, ce_i, sclk, cs_n, sdi, sdo, oe, thru, wr_valid, resync;
  spi_chain_pkg::reg_write_t wr, wr_last;
  int failures, cmp_count, wr_n, rs_n;
  logic [7:0] r, t;

  daisy_chain_serial_control_port DUT (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .ce_i(ce_i), .serial_clk_i(sclk), .chip_sel_n_i(cs_n), .serial_in_i(sdi),
    .serial_out_o(sdo), .serial_out_oe_o(oe), .daisy_through_out_o(thru),
    .wr_valid_o(wr_valid), .wr_o(wr), .resync_o(resync));
  spi_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo),
    .sdo_oe_i(oe), .thru_i(thru));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  always @(negedge sys_clk_i)
  begin
    if (wr_valid === 1'b1)
    begin
      wr_n++;
      wr_last = wr;
    end
    if (resync === 1'b1)
      rs_n++;
  end

  function automatic logic [7:0] mk(input logic b, input logic rw, input logic [3:0] ch);
    return {b, rw, 2'b10, ch[0], ch[1], ch[2], ch[3]};
  endfunction : mk

  // one operation; wide keeps select low for a second data byte
  task automatic op(input logic [7:0] c, a, d, input bit w, input logic [7:0] fwd,
                    output logic [7:0] rd);
    logic [7:0] r2;
    host.xfer(c, 8, rd, t);
    if (c[5:4] == 2'b10)
      `CHK(t, fwd)
    host.xfer(a, 8, rd, t);
    `CHK(t, a)
    host.xfer(d, 8, rd, t);
    if (w)
    begin
      host.xfer(~d, 8, r2, t);
      `CHK(r2, rd)
    end
    host.stop(1);
  endtask : op

  task automatic evt(input int nw, input int nr);
    repeat (20) @(negedge sys_clk_i);
    `CHK(wr_n, nw)
    `CHK(rs_n, nr)
  endtask : evt

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  initial
  begin
    #300000;
    failures++;
    wrap_up();
  end

  initial
  begin
    reset_n_i = 1'b0;
    ce_i = 1'b1;
    host.stop(4);
    repeat (4) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    host.stop(3);
    op(mk(0, 0, 0), 8'hc5, 8'h5a, 0, mk(0, 0, 4'hf), r);
    evt(1, 0);
    `CHK(wr_last, {6'h05, 8'h5a})
    op(mk(0, 1, 0), 8'h05, 8'h00, 0, mk(0, 1, 4'hf), r);
    `CHK(r, 8'h5a)
    op(mk(0, 0, 0), 8'h09, 8'ha3, 1, mk(0, 0, 4'hf), r);
    evt(2, 0);
    `CHK(wr_last, {6'h09, 8'ha3})
    op(mk(0, 1, 0), 8'h09, 8'h00, 1, mk(0, 1, 4'hf), r);
    `CHK(r, 8'ha3)
    op(mk(0, 0, 2), 8'h05, 8'hee, 0, mk(0, 0, 1), r);
    evt(2, 0);
    op(mk(1, 0, 3), 8'h0c, 8'h71, 0, mk(1, 0, 3), r);
    evt(3, 0);
    `CHK(wr_last, {6'h0c, 8'h71})
    op(mk(1, 1, 0), 8'h0c, 8'h00, 0, mk(1, 1, 0), r);
    `CHK(r, 8'hzz)
    op(8'h10, 8'h05, 8'h11, 0, 8'h00, r);
    evt(3, 0);
    // select released after five data bits
    host.xfer(mk(0, 0, 0), 8, r, t);
    host.xfer(8'h05, 8, r, t);
    host.xfer(8'h22, 5, r, t);
    host.stop(1);
    evt(3, 1);
    op(mk(0, 1, 0), 8'h05, 8'h00, 0, mk(0, 1, 4'hf), r);
    `CHK(r, 8'h5a)
    // write while the system side is frozen; the strobe shows once thawed
    ce_i = 1'b0;
    op(mk(0, 0, 0), 8'h3f, 8'hc3, 0, mk(0, 0, 4'hf), r);
    evt(3, 1);
    ce_i = 1'b1;
    evt(4, 1);
    `CHK(wr_last, {6'h3f, 8'hc3})
    wrap_up();
  end
endmodule : daisy_chain_serial_control_port_tb
